// ---- rtl/hbad_decoder.sv ----
// Host bus address decoder: I/O and memory selects with APB setup registers
//
// Overview of operation
// - Claim I/O only inside one 16-byte block
// - I/O straps give 12-bit base versus A15-A4
// - Eight I/O bases from 0x260 to 0x3E0
// - Default I/O straps answer at 0x300
// - RAM hidden until node ID loaded, enabled
// - Wide strap: reset into 16-bit, memory enabled
// - Config bit picks I/O-mapped or memory-mapped RAM
// - Decode bit: ROM size or wide range
// - Wide bus sees RAM as 1K words
// - Memory straps give 9-bit value versus A19-A11
// - A13 high selects PROM, low RAM
// - A12-A11 against two low straps place RAM
// - Thirty-two placements from segment C000 to E000
// - Default memory straps put RAM at D000
// - Memory selects only when A23-A20 are zero; I/O selects ignore them
// - First latch follows address while BALE high
// - Unconnected BALE: only second stage latches
// - I/O-mapped mode with decode bit set: PROM fills whole segment
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ns
module hbad_decoder #(
  parameter int SYNC_STAGES = 2
) (
  // Clock and reset
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RESET_N_IN,
  // Host expansion bus
  input  wire logic [23:0] HOST_ADDR_IN,
  input  wire logic        HOST_BALE_IN,
  input  wire logic        HOST_IOR_N_IN,
  input  wire logic        HOST_IOW_N_IN,
  input  wire logic        HOST_MEMR_N_IN,
  input  wire logic        HOST_MEMW_N_IN,
  // Jumper straps
  input  wire logic [2:0]  IO_BLOCK_SELECT_STRAPS_IN,
  input  wire logic [4:0]  MEM_SEGMENT_SELECT_STRAPS_IN,
  input  wire logic        MEM_ENABLE_WIDE_STRAP_IN,
  input  wire logic        BALE_CONNECT_STRAP_IN,
  // APB slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // Decoded selects
  output logic             IO_SEL_OUT,
  output logic             RAM_SEL_OUT,
  output logic             PROM_SEL_OUT,
  output logic             MEM_WIDE_OUT,
  output logic      [3:0]  IO_OFFSET_OUT,
  output logic      [10:0] RAM_ADDR_OUT
);

  localparam int SYN_W = 39;

  logic [SYN_W-1:0]  syn_raw;
  logic [SYN_W-1:0]  syn_s;
  logic [23:0]       addr_s;
  logic              bale_s;
  logic              ior_s;
  logic              iow_s;
  logic              memr_s;
  logic              memw_s;
  logic [2:0]        ios_s;
  logic [4:0]        ms_s;
  logic              wide_strap_s;
  logic              bale_conn_s;
  logic              io_strb;
  logic              mem_strb;
  logic [11:0]       io_base_v;
  logic [8:0]        mem_val_v;
  logic              ram_open;
  logic [23:0]       a1_q, a1_d;
  logic [23:0]       a2_q, a2_d;
  logic [23:0]       src;
  hbad_pkg::hbad_cyc_t state_q, state_d;
  logic              io_sel_q, io_sel_d;
  logic              ram_sel_q, ram_sel_d;
  logic              prom_sel_q, prom_sel_d;
  logic              wide_q, wide_d;
  logic [3:0]        ofs_q, ofs_d;
  logic [10:0]       ram_addr_q, ram_addr_d;
  logic              top_ok;
  logic              io_hit;
  logic              ram_mem_hit;
  logic              ram_io_hit;
  logic              prom_hit;
  logic [10:0]       ram_base;
  logic [3:0]        cfg_q, cfg_d;
  logic [7:0]        node_q, node_d;
  logic [10:0]       ptr_q, ptr_d;
  logic              init_q, init_d;
  logic              pready_q, pready_d;
  logic [31:0]       prdata_q, prdata_d;
  logic              pslverr_q, pslverr_d;
  logic              wr_acc;

  // I/O block base from the three straps
  function automatic logic [11:0] io_base_f(input logic [2:0] s);
    return hbad_pkg::IO_BASE_TBL[s ^ hbad_pkg::IO_STRAP_XOR];
  endfunction

  // Segment plus RAM slot from the five straps, matched against A19-A11
  function automatic logic [8:0] mem_val_f(input logic [4:0] s);
    return {hbad_pkg::SEG_TBL[s[4:2] ^ hbad_pkg::MEM_STRAP_XOR], 1'b0, s[1:0]};
  endfunction

  // Register offsets that answer on the bus
  function automatic logic reg_known_f(input logic [7:0] a);
    return (a == hbad_pkg::REG_CONFIG) || (a == hbad_pkg::REG_NODE) ||
           (a == hbad_pkg::REG_PTR) || (a == hbad_pkg::REG_STATUS);
  endfunction

  // Every bus pin and strap passes the synchroniser
  assign syn_raw = {HOST_ADDR_IN, HOST_BALE_IN, HOST_IOR_N_IN, HOST_IOW_N_IN,
                    HOST_MEMR_N_IN, HOST_MEMW_N_IN, IO_BLOCK_SELECT_STRAPS_IN,
                    MEM_SEGMENT_SELECT_STRAPS_IN, MEM_ENABLE_WIDE_STRAP_IN,
                    BALE_CONNECT_STRAP_IN};

  hbad_sync #(
    .WIDTH  (SYN_W),
    .STAGES (SYNC_STAGES)
  ) u_sync (
    .clk_in (CORE_CLK_IN),
    .d_in   (syn_raw),
    .q_out  (syn_s)
  );

  // Unpack synchronised pins; strobes become active high
  assign addr_s       = syn_s[38:15];
  assign bale_s       = syn_s[14];
  assign ior_s        = ~syn_s[13];
  assign iow_s        = ~syn_s[12];
  assign memr_s       = ~syn_s[11];
  assign memw_s       = ~syn_s[10];
  assign ios_s        = syn_s[9:7];
  assign ms_s         = syn_s[6:2];
  assign wide_strap_s = syn_s[1];
  assign bale_conn_s  = syn_s[0];
  assign io_strb      = ior_s | iow_s;
  assign mem_strb     = memr_s | memw_s;
  assign io_base_v    = io_base_f(ios_s);
  assign mem_val_v    = mem_val_f(ms_s);
  assign ram_open     = cfg_q[hbad_pkg::CFG_MEMEN_BIT] && (node_q != hbad_pkg::NODE_RST);
  assign wr_acc       = PSEL_IN & PENABLE_IN & pready_q & PWRITE_IN;

  // Address latches and cycle tracking
  always_comb begin
    a1_d = bale_s ? addr_s : a1_q;
    src  = bale_conn_s ? a1_q : addr_s;
    a2_d = (state_q == hbad_pkg::HBAD_IDLE) ? src : a2_q;
    case (state_q)
      hbad_pkg::HBAD_IDLE: begin
        if (io_strb) begin
          state_d = hbad_pkg::HBAD_IO;
        end else if (mem_strb) begin
          state_d = hbad_pkg::HBAD_MEM;
        end else begin
          state_d = hbad_pkg::HBAD_IDLE;
        end
      end
      hbad_pkg::HBAD_IO: begin
        state_d = io_strb ? hbad_pkg::HBAD_IO : hbad_pkg::HBAD_IDLE;
      end
      hbad_pkg::HBAD_MEM: begin
        state_d = mem_strb ? hbad_pkg::HBAD_MEM : hbad_pkg::HBAD_IDLE;
      end
      default: begin
        state_d = hbad_pkg::HBAD_IDLE;
      end
    endcase
  end

  // Hit decode on the held cycle address
  always_comb begin
    top_ok      = a2_d[23:20] == hbad_pkg::LOW_MEG;
    io_hit      = a2_d[15:4] == io_base_v;
    ram_mem_hit = !cfg_q[hbad_pkg::CFG_IO_BIT] && ram_open && top_ok &&
                  (a2_d[19:11] == mem_val_v);
    ram_io_hit  = cfg_q[hbad_pkg::CFG_IO_BIT] && ram_open && io_hit &&
                  (a2_d[3:0] == hbad_pkg::IO_DATA_OFS);
    prom_hit    = top_ok && (a2_d[19:14] == mem_val_v[8:3]) &&
                  (a2_d[13] || (cfg_q[hbad_pkg::CFG_IO_BIT] && cfg_q[hbad_pkg::CFG_DEC_BIT]));
    io_sel_d    = (state_d == hbad_pkg::HBAD_IO) && io_hit;
    ram_sel_d   = ((state_d == hbad_pkg::HBAD_MEM) && ram_mem_hit) ||
                  ((state_d == hbad_pkg::HBAD_IO) && ram_io_hit);
    prom_sel_d  = (state_d == hbad_pkg::HBAD_MEM) && prom_hit;
    // Wide indication over the RAM alone or its 128K range
    wide_d      = (state_d == hbad_pkg::HBAD_MEM) && cfg_q[hbad_pkg::CFG_WIDE_BIT] &&
                  !cfg_q[hbad_pkg::CFG_IO_BIT] && top_ok &&
                  (cfg_q[hbad_pkg::CFG_DEC_BIT] ? (a2_d[19:17] == mem_val_v[8:6]) : ram_mem_hit);
    ofs_d       = a2_d[3:0];
    ram_base    = cfg_q[hbad_pkg::CFG_IO_BIT] ? ptr_q : a2_d[10:0];
    ram_addr_d  = cfg_q[hbad_pkg::CFG_WIDE_BIT] ? {1'b0, ram_base[10:1]} : ram_base;
  end

  // Host-side registers
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESET_N_IN) begin
      state_q    <= hbad_pkg::HBAD_IDLE;
      a1_q       <= '0;
      a2_q       <= '0;
      io_sel_q   <= 1'b0;
      ram_sel_q  <= 1'b0;
      prom_sel_q <= 1'b0;
      wide_q     <= 1'b0;
      ofs_q      <= '0;
      ram_addr_q <= '0;
    end else begin
      state_q    <= state_d;
      a1_q       <= a1_d;
      a2_q       <= a2_d;
      io_sel_q   <= io_sel_d;
      ram_sel_q  <= ram_sel_d;
      prom_sel_q <= prom_sel_d;
      wide_q     <= wide_d;
      ofs_q      <= ofs_d;
      ram_addr_q <= ram_addr_d;
    end
  end

  // Setup registers, strap capture and sequential RAM pointer
  always_comb begin
    cfg_d  = cfg_q;
    node_d = node_q;
    ptr_d  = ptr_q;
    init_d = 1'b1;
    if ((state_q == hbad_pkg::HBAD_IO) && (state_d == hbad_pkg::HBAD_IDLE) && ram_sel_q) begin
      ptr_d = ptr_q + (cfg_q[hbad_pkg::CFG_WIDE_BIT] ? hbad_pkg::STEP_WORD : hbad_pkg::STEP_BYTE);
    end
    if (wr_acc) begin
      case (PADDR_IN)
        hbad_pkg::REG_CONFIG: cfg_d  = PWDATA_IN[3:0];
        hbad_pkg::REG_NODE:   node_d = PWDATA_IN[7:0];
        hbad_pkg::REG_PTR:    ptr_d  = PWDATA_IN[10:0];
        default:              cfg_d  = cfg_q;
      endcase
    end
    // First cycle after reset release catches the wide strap
    if (!init_q && wide_strap_s) begin
      cfg_d[hbad_pkg::CFG_WIDE_BIT]  = 1'b1;
      cfg_d[hbad_pkg::CFG_MEMEN_BIT] = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESET_N_IN) begin
      cfg_q  <= hbad_pkg::CFG_RST;
      node_q <= hbad_pkg::NODE_RST;
      ptr_q  <= hbad_pkg::PTR_RST;
      init_q <= 1'b0;
    end else begin
      cfg_q  <= cfg_d;
      node_q <= node_d;
      ptr_q  <= ptr_d;
      init_q <= init_d;
    end
  end

  // APB answer: one wait state, read data and error with ready
  always_comb begin
    pready_d  = PSEL_IN & PENABLE_IN & ~pready_q;
    prdata_d  = '0;
    pslverr_d = 1'b0;
    if (pready_d) begin
      pslverr_d = ~reg_known_f(PADDR_IN);
      if (!PWRITE_IN) begin
        case (PADDR_IN)
          hbad_pkg::REG_CONFIG: prdata_d[3:0]  = cfg_q;
          hbad_pkg::REG_NODE:   prdata_d[7:0]  = node_q;
          hbad_pkg::REG_PTR:    prdata_d[10:0] = ptr_q;
          hbad_pkg::REG_STATUS: begin
            prdata_d[hbad_pkg::STS_OPEN_BIT] = ram_open;
            prdata_d[hbad_pkg::STS_IO_BIT]   = io_sel_q;
            prdata_d[hbad_pkg::STS_RAM_BIT]  = ram_sel_q;
            prdata_d[hbad_pkg::STS_PROM_BIT] = prom_sel_q;
          end
          default: prdata_d = '0;
        endcase
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESET_N_IN) begin
      pready_q  <= 1'b0;
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= pready_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Outputs straight from flops
  assign PRDATA_OUT    = prdata_q;
  assign PREADY_OUT    = pready_q;
  assign PSLVERR_OUT   = pslverr_q;
  assign IO_SEL_OUT    = io_sel_q;
  assign RAM_SEL_OUT   = ram_sel_q;
  assign PROM_SEL_OUT  = prom_sel_q;
  assign MEM_WIDE_OUT  = wide_q;
  assign IO_OFFSET_OUT = ofs_q;
  assign RAM_ADDR_OUT  = ram_addr_q;

  // Checks on the decode
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  a_io_block_match: assert property (io_sel_q |-> a2_q[15:4] == io_base_v)
    else $error("I/O select outside strapped block");
  a_io_default_base: assert property (ios_s == 3'h0 |-> io_base_v == 12'h030)
    else $error("default I/O straps not at 0x300");
  a_ram_gate_open: assert property (ram_sel_q |-> $past(ram_open))
    else $error("RAM selected while hidden");
  a_strap_wide_boot: assert property ($rose(init_q) && $past(wide_strap_s) |->
    cfg_q[hbad_pkg::CFG_WIDE_BIT] && cfg_q[hbad_pkg::CFG_MEMEN_BIT])
    else $error("wide strap not caught after reset");
  a_io_mode_ram: assert property (ram_sel_q && state_q == hbad_pkg::HBAD_IO |->
    cfg_q[hbad_pkg::CFG_IO_BIT] && a2_q[3:0] == hbad_pkg::IO_DATA_OFS)
    else $error("I/O RAM access outside I/O-mapped mode");
  a_mem_ram_match: assert property (ram_sel_q && state_q == hbad_pkg::HBAD_MEM |->
    a2_q[19:11] == mem_val_v && !a2_q[13])
    else $error("memory RAM select on wrong address");
  a_prom_upper_half: assert property (prom_sel_q && !cfg_q[hbad_pkg::CFG_IO_BIT] |-> a2_q[13])
    else $error("PROM selected with A13 low");
  a_mem_default_seg: assert property (ms_s == 5'h00 |-> mem_val_v == 9'h1A0)
    else $error("default memory straps not at D000");
  a_low_megabyte: assert property (ram_sel_q || prom_sel_q || wide_q |->
    state_q == hbad_pkg::HBAD_IO || a2_q[23:20] == 4'h0)
    else $error("memory select above first megabyte");
  a_word_address: assert property (ram_sel_q && cfg_q[hbad_pkg::CFG_WIDE_BIT] |-> !ram_addr_q[10])
    else $error("word address beyond 1K");
  a_latch_hold: assert property (!bale_s |=> a1_q == $past(a1_q))
    else $error("first latch moved with BALE low");
  a_sel_release: assert property (!io_strb && !mem_strb |=> !io_sel_q && !ram_sel_q && !prom_sel_q)
    else $error("select outlived its strobe");

  c_io_hit:   cover property (io_strb ##1 io_sel_q);
  c_ram_hit:  cover property (mem_strb ##1 ram_sel_q && state_q == hbad_pkg::HBAD_MEM);
  c_prom_hit: cover property (mem_strb ##1 prom_sel_q);
  c_apb_wr:   cover property (wr_acc && PADDR_IN == hbad_pkg::REG_CONFIG);

endmodule

// ---- rtl/hbad_pkg.sv ----
// Constants and types for the host bus address decoder
package hbad_pkg;

  // APB register byte offsets
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_NODE   = 8'h04;
  localparam logic [7:0] REG_PTR    = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;

  // Configuration register field positions
  localparam int unsigned CFG_IO_BIT    = 0;
  localparam int unsigned CFG_DEC_BIT   = 1;
  localparam int unsigned CFG_WIDE_BIT  = 2;
  localparam int unsigned CFG_MEMEN_BIT = 3;
  localparam int unsigned CFG_W         = 4;

  // Status register field positions
  localparam int unsigned STS_OPEN_BIT = 0;
  localparam int unsigned STS_IO_BIT   = 1;
  localparam int unsigned STS_RAM_BIT  = 2;
  localparam int unsigned STS_PROM_BIT = 3;

  // Reset values
  localparam logic [3:0]  CFG_RST  = 4'h0;
  localparam logic [7:0]  NODE_RST = 8'h00;
  localparam logic [10:0] PTR_RST  = 11'h000;

  // Strap decode: all straps low selects the factory default entry
  localparam logic [2:0] IO_STRAP_XOR  = 3'h4;
  localparam logic [2:0] MEM_STRAP_XOR = 3'h3;

  // I/O block bases, address bits 15..4
  localparam logic [11:0] IO_BASE_TBL [8] = '{
    12'h026, 12'h029, 12'h02E, 12'h02F, 12'h030, 12'h035, 12'h038, 12'h03E};

  // 16K memory segments, address bits 19..14
  localparam logic [5:0] SEG_TBL [8] = '{
    6'h30, 6'h31, 6'h33, 6'h34, 6'h35, 6'h36, 6'h37, 6'h38};

  // I/O offset of the sequential RAM data port
  localparam logic [3:0] IO_DATA_OFS = 4'hC;

  // Upper address nibble of the first megabyte
  localparam logic [3:0] LOW_MEG = 4'h0;

  // Pointer steps for byte and word transfers
  localparam logic [10:0] STEP_BYTE = 11'h001;
  localparam logic [10:0] STEP_WORD = 11'h002;

  // Host bus cycle states
  typedef enum logic [2:0] {
    HBAD_IDLE = 3'b001,
    HBAD_IO   = 3'b010,
    HBAD_MEM  = 3'b100
  } hbad_cyc_t;

endpackage

// ---- rtl/hbad_sync.sv ----
// Multi-stage synchroniser for pins from outside the core clock
`timescale 1ns/1ns
module hbad_sync #(
  parameter int WIDTH  = 1,
  parameter int STAGES = 2
) (
  // Clock
  input  wire logic             clk_in,
  // Asynchronous input and synchronised output
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] stage_q [STAGES];

  // Fewer than two stages would not settle metastability
  if (STAGES < 2) begin : g_bad_stages
    $error("hbad_sync needs at least two stages");
  end

  // Shift chain; only the next stage reads each flop
  always_ff @(posedge clk_in) begin
    stage_q[0] <= d_in;
    for (int i = 1; i < STAGES; i++) begin
      stage_q[i] <= stage_q[i-1];
    end
  end

  assign q_out = stage_q[STAGES-1];

endmodule

// ---- testbench/hbad_decoder_tb.sv ----
// Self-checking bench for the host bus address decoder
`timescale 1ns/1ns
module hbad_decoder_tb;
  localparam logic [11:0] IO_B [8] = '{12'h026, 12'h029, 12'h02E, 12'h02F, 12'h030, 12'h035, 12'h038, 12'h03E};
  localparam logic [5:0]  SEGS [8] = '{6'h30, 6'h31, 6'h33, 6'h34, 6'h35, 6'h36, 6'h37, 6'h38};
  logic        clk;
  logic        rst_n;
  logic [23:0] h_addr;
  logic        h_bale;
  logic [3:0]  h_strb_n;
  logic [2:0]  ios;
  logic [4:0]  ms;
  logic        wide_strap;
  logic        bale_con;
  logic        psel, penable, pwrite, pready, pslverr, err, hok;
  logic [7:0]  paddr, node;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  sels, ofs, cfg, hs, ho;
  logic [10:0] ra, hr;
  logic [2:0]  k;
  integer      seed, fails, n_checks;
  integer      cycles = 0;

  hbad_decoder dut (
    .CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .HOST_ADDR_IN(h_addr), .HOST_BALE_IN(h_bale),
    .HOST_IOR_N_IN(h_strb_n[3]), .HOST_IOW_N_IN(h_strb_n[2]), .HOST_MEMR_N_IN(h_strb_n[1]),
    .HOST_MEMW_N_IN(h_strb_n[0]), .IO_BLOCK_SELECT_STRAPS_IN(ios), .MEM_SEGMENT_SELECT_STRAPS_IN(ms),
    .MEM_ENABLE_WIDE_STRAP_IN(wide_strap), .BALE_CONNECT_STRAP_IN(bale_con), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .IO_SEL_OUT(sels[3]), .RAM_SEL_OUT(sels[2]),
    .PROM_SEL_OUT(sels[1]), .MEM_WIDE_OUT(sels[0]), .IO_OFFSET_OUT(ofs), .RAM_ADDR_OUT(ra)
  );
  hbad_host_model host (
    .clk_in(clk), .addr_out(h_addr), .bale_out(h_bale), .strb_n_out(h_strb_n), .sels_in(sels),
    .ofs_in(ofs), .ra_in(ra)
  );

  // 10 MHz clock
  initial clk = 1'b0;
  always #50 clk = ~clk;

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // APB transfer: setup, then access held until PREADY is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rdat,
                     output logic e);
    integer n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n = n + 1;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", pready, 32'h0000_0001);
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, rd, err);
    chk(what, rd, exp);
  endtask

  task automatic setcfg(input logic [3:0] c, input logic [7:0] nd);
    cfg = c;
    node = nd;
    apb(1'b1, hbad_pkg::REG_CONFIG, {28'h000_0000, c}, rd, err);
    apb(1'b1, hbad_pkg::REG_NODE, {24'h00_0000, nd}, rd, err);
  endtask

  task automatic rst();
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  // Expected selects {io, ram, prom, wide} from straps, configuration and node
  function automatic logic [3:0] exp_sels(input logic io, input logic [23:0] a);
    logic       seg, ram, open;
    logic [5:0] sg;
    sg = SEGS[ms[4:2] ^ 3'h3];
    open = cfg[3] && (node != 8'h00);
    seg = !io && (a[23:20] == 4'h0) && (a[19:14] == sg);
    ram = seg && !cfg[0] && !a[13] && (a[12:11] == ms[1:0]) && open;
    exp_sels = {io && (a[15:4] == IO_B[ios ^ 3'h4]), ram, seg && (a[13] || (cfg[0] && cfg[1])),
                !io && cfg[2] && !cfg[0] && (cfg[1] ? (a[23:20] == 4'h0 && a[19:17] == sg[5:3]) : ram)};
  endfunction

  // Random address aimed near the candidate blocks and segments
  function automatic logic [23:0] rnd_addr(input logic io);
    logic [23:0] a;
    a = $random(seed);
    if (io) begin
      if (($random(seed) & 3) != 0) a[15:4] = IO_B[$random(seed) & 7];
      if (a[3:0] == 4'hC) a[0] = 1'b1;
    end else begin
      if (($random(seed) & 3) != 0) a[23:20] = 4'h0;
      a[19:14] = SEGS[$random(seed) & 7];
    end
    rnd_addr = a;
  endfunction

  task automatic run(input logic io, input logic wr, input logic scr, input logic [23:0] a);
    logic [3:0] e;
    host.cycle(io, wr, scr, !bale_con, a, hs, ho, hr, hok);
    e = exp_sels(io, a);
    chk("selects", hs, e);
    chk("select timing", hok, 32'h0000_0001);
    if (e[3]) chk("io offset", ho, a[3:0]);
    if (e[2]) chk("ram addr", hr, cfg[2] ? {1'b0, a[10:1]} : a[10:0]);
  endtask

  // Main sequence
  initial begin
    seed = 32'h768d_f406;
    fails = 0;
    n_checks = 0;
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {ios, ms, bale_con, cfg, node} = '0;
    wide_strap = 1'b1;
    rst();
    cfg = 4'hC;
    rchk("config", hbad_pkg::REG_CONFIG, 32'h0000_000C);
    rchk("status", hbad_pkg::REG_STATUS, 32'h0000_0000);
    run(1'b0, 1'b0, 1'b0, 24'h0D_0000);
    run(1'b0, 1'b0, 1'b1, 24'h0D_2000);
    run(1'b1, 1'b0, 1'b1, 24'h00_0305);
    run(1'b1, 1'b1, 1'b0, 24'h00_0310);
    setcfg(4'hC, 8'h5A);
    rchk("status", hbad_pkg::REG_STATUS, 32'h0000_0001);
    run(1'b0, 1'b0, 1'b0, 24'h0D_0446);
    run(1'b0, 1'b1, 1'b0, 24'h1D_0000);
    run(1'b0, 1'b0, 1'b0, 24'h0D_0800);
    apb(1'b0, 8'h10, 32'h0000_0000, rd, err);
    chk("unmapped data", rd, 32'h0000_0000);
    chk("unmapped error", err, 32'h0000_0001);
    for (int i = 0; i < 60; i++) begin
      ios <= 3'($random(seed));
      ms <= 5'($random(seed));
      bale_con <= 1'($random(seed));
      k = 3'($random(seed));
      setcfg(4'($random(seed)), k[2] ? 8'h00 : 8'h77);
      run(k[0], k[1], k[2] & bale_con, rnd_addr(k[0]));
    end
    ios <= 3'h0;
    setcfg(4'h9, 8'h01);
    apb(1'b1, hbad_pkg::REG_PTR, 32'h0000_07FE, rd, err);
    host.cycle(1'b1, 1'b0, 1'b0, !bale_con, 24'h00_030C, hs, ho, hr, hok);
    chk("ptr addr", hr, 32'h0000_07FE);
    host.cycle(1'b1, 1'b1, 1'b0, !bale_con, 24'h00_030C, hs, ho, hr, hok);
    chk("ptr addr", hr, 32'h0000_07FF);
    rchk("ptr", hbad_pkg::REG_PTR, 32'h0000_0000);
    run(1'b0, 1'b0, 1'b0, 24'h0D_0000);
    // Wide I/O-mapped RAM: word address from the pointer, step of two
    setcfg(4'hD, 8'h01);
    apb(1'b1, hbad_pkg::REG_PTR, 32'h0000_07FE, rd, err);
    host.cycle(1'b1, 1'b0, 1'b0, !bale_con, 24'h00_030C, hs, ho, hr, hok);
    chk("ptr sels", hs, 32'h0000_000C);
    chk("ptr word addr", hr, 32'h0000_03FF);
    rchk("ptr", hbad_pkg::REG_PTR, 32'h0000_0000);
    wide_strap <= 1'b0;
    rst();
    cfg = 4'h0;
    node = 8'h00;
    rchk("config", hbad_pkg::REG_CONFIG, 32'h0000_0000);
    run(1'b0, 1'b0, 1'b0, 24'h0D_0000);
    end_of_test();
  end
endmodule

// ---- testbench/hbad_host_model.sv ----
// Behavioural host processor driving the expansion bus side of the decoder
`timescale 1ns/1ns
module hbad_host_model (
  // Clock
  input  wire logic        clk_in,
  // Host bus lines: strobes are IOR, IOW, MEMR, MEMW from bit 3 down
  output logic      [23:0] addr_out,
  output logic             bale_out,
  output logic      [3:0]  strb_n_out,
  // Decoder outputs: io, ram, prom, wide; offset; RAM address
  input  wire logic [3:0]  sels_in,
  input  wire logic [3:0]  ofs_in,
  input  wire logic [10:0] ra_in
);
  // Idle bus at time zero
  initial begin
    addr_out = 24'h00_0000;
    bale_out = 1'b0;
    strb_n_out = 4'hF;
  end

  // One host cycle; reports selects and whether they rose and fell on time
  task automatic cycle(input logic io, input logic wr, input logic scr, input logic bhi, input logic [23:0] a,
                       output logic [3:0] sels, output logic [3:0] ofs, output logic [10:0] ra, output logic ok);
    logic [3:0] s_early;
    logic [3:0] s_late;
    @(posedge clk_in);
    addr_out <= a;
    bale_out <= 1'b1;
    repeat (2) @(posedge clk_in);
    bale_out <= bhi;
    strb_n_out <= ~(4'b1000 >> {~io, wr});
    @(posedge clk_in);
    // Lines may move once BALE has closed the first latch stage
    if (scr) addr_out <= ~a;
    repeat (2) @(posedge clk_in);
    s_early = sels_in;
    @(posedge clk_in);
    sels = sels_in;
    ofs = ofs_in;
    ra = ra_in;
    repeat (2) @(posedge clk_in);
    strb_n_out <= 4'hF;
    repeat (3) @(posedge clk_in);
    s_late = sels_in;
    @(posedge clk_in);
    ok = (s_early === 4'h0) && (s_late === sels) && (sels_in === 4'h0);
    // Without BALE the address stayed put for the whole cycle unless scr was set; now released
    addr_out <= ~a;
  endtask
endmodule
